/* File: verification/op_sequencer_model.sv */
// sequencer model: issues completed instructions and keeps the saved status characters
`timescale 1ns/100ps

module op_sequencer_model (
	input wire logic i_clk_sys,
	input wire flags_pkg::resp_s i_resp,
	output flags_pkg::op_s o_op,
	output logic o_base_zero
);
	logic [3:0] reserved_chr = 4'h0;
	logic [3:0] stack_chr = 4'h0;

	initial begin
		o_op = '0;
		o_base_zero = 1'b1;
	end

	// taken on the falling edge so an issue at the next rising edge sees the new character
	always @(negedge i_clk_sys) begin
		if (i_resp.valid && i_resp.save && i_resp.save_stack) stack_chr <= i_resp.save_char;
		if (i_resp.valid && i_resp.save && !i_resp.save_stack) reserved_chr <= i_resp.save_char;
	end

	// gap of one or more idle cycles; the restore character comes from memory
	task automatic issue(input flags_pkg::op_e k, input logic [4:0] b, input logic bz,
		input int gap);
		repeat (gap) @(posedge i_clk_sys);
		o_op.valid <= 1'b1;
		o_op.kind <= k;
		o_op.ovf <= b[4];
		o_op.exp_ovf <= b[3];
		o_op.cmp <= b[2:1];
		o_op.mode_val <= b[0];
		o_op.char_in <= (k == flags_pkg::OP_EXIT) ? stack_chr :
			((k == flags_pkg::OP_BR_REINST) ? reserved_chr : ~o_op.char_in);
		o_base_zero <= bz;
		@(posedge i_clk_sys);
		o_op.valid <= 1'b0;
		// memory bus no longer driven: show a changing pattern
		o_op.char_in <= ~o_op.char_in;
	endtask : issue
endmodule : op_sequencer_model

/* File: verification/test_processor_status_flags.sv */
// self-checking bench for the processor status flag block
`timescale 1ns/100ps

module test_processor_status_flags;
	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	logic i_io_complete = 1'b0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h00000000;
	logic [3:0] i_wstrb = 4'hf;
	flags_pkg::op_s op;
	logic base_zero;
	flags_pkg::resp_s o_resp;
	flags_pkg::mode_e o_mode;
	logic o_control_state, o_priv_ok, o_intr_pending, o_overflow, o_code_ascii;
	logic [1:0] o_cmp, o_bresp, o_rresp;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [31:0] o_rdata;
	int fail_count = 0;
	int comparisons = 0;
	logic [31:0] rng = 32'h0000634c;
	logic m_ovf = 1'b0, m_code = 1'b0, m_ctl = 1'b1, m_pend = 1'b0, m_base = 1'b1, sv_stk = 1'b0;
	logic [1:0] m_cmp = 2'h0;
	logic [3:0] res_chr = 4'h0, stk_chr = 4'h0, sv_chr = 4'h0;

	always #2 i_clk_sys = ~i_clk_sys;

	op_sequencer_model seq_inst (.i_clk_sys(i_clk_sys), .i_resp(o_resp), .o_op(op),
		.o_base_zero(base_zero));

	processor_status_flags processor_status_flags_inst (.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn), .i_op(op), .i_base_zero(base_zero), .i_io_complete(i_io_complete),
		.o_resp(o_resp), .o_mode(o_mode), .o_control_state(o_control_state),
		.o_priv_ok(o_priv_ok), .o_intr_pending(o_intr_pending), .o_overflow(o_overflow),
		.o_cmp(o_cmp), .o_code_ascii(o_code_ascii), .i_awvalid(i_awvalid),
		.o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		logic done;
		done = 1'b0;
		r = 2'bxx;
		@(posedge i_clk_sys);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		// ready only once the response stands, so the slave has to hold it a cycle
		for (int n = 0; n < 50 && !done; n++) begin
			@(posedge i_clk_sys);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_bvalid && i_bready) begin
				r = o_bresp;
				i_bready <= 1'b0;
				done = 1'b1;
			end else if (o_bvalid) begin
				i_bready <= 1'b1;
			end
		end
		check(32'(r), 32'(er));
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		logic done;
		done = 1'b0;
		{d, r} = 34'bx;
		@(posedge i_clk_sys);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(posedge i_clk_sys);
			if (o_arready) i_arvalid <= 1'b0;
			if (o_rvalid) begin
				{d, r} = {o_rdata, o_rresp};
				i_rready <= 1'b0;
				done = 1'b1;
			end
		end
		check(d, e);
		check(32'(r), 32'(er));
	endtask : bus_read

	function automatic logic [31:0] status_word();
		return {22'h0, !m_ctl, !m_base, 1'b0, m_pend, m_base, m_ctl, m_code, m_ovf, m_cmp};
	endfunction : status_word

	// one instruction through the partner, then the model's answer against the block's
	task automatic step(input flags_pkg::op_e k, input logic [4:0] b, input logic bz, input int gap);
		logic ovn, cb, save, stk, intr;
		logic [3:0] chr;
		flags_pkg::resp_s er, gr;
		logic [8:0] gs, es;
		cb = m_code;
		intr = !m_ctl && m_pend && k != flags_pkg::OP_BR_COMM;
		ovn = (k inside {flags_pkg::OP_ARITH, flags_pkg::OP_FLOAT, flags_pkg::OP_MOVE_NUM,
			flags_pkg::OP_MOVE_ALPHA}) && b[4] || k == flags_pkg::OP_FLOAT && b[3];
		if (ovn) m_ovf = 1'b1;
		if (k == flags_pkg::OP_BRANCH_OVF) m_ovf = 1'b0;
		if (k inside {flags_pkg::OP_ARITH, flags_pkg::OP_MULT, flags_pkg::OP_FLOAT,
			flags_pkg::OP_COMPARE, flags_pkg::OP_MOVE_NUM, flags_pkg::OP_MOVE_ALPHA,
			flags_pkg::OP_BIT_TEST, flags_pkg::OP_LOGICAL, flags_pkg::OP_SCAN,
			flags_pkg::OP_SCAN_DELIM, flags_pkg::OP_EDIT, flags_pkg::OP_SCAN_RESULT,
			flags_pkg::OP_SEARCH}) m_cmp = b[2:1];
		if (k == flags_pkg::OP_SET_MODE) m_code = b[0];
		if (k == flags_pkg::OP_BR_REINST) {m_code, m_ovf, m_cmp} = res_chr;
		if (k == flags_pkg::OP_EXIT) {m_code, m_ovf, m_cmp} = stk_chr;
		if (k == flags_pkg::OP_BR_REINST) m_ctl = 1'b0;
		if (k == flags_pkg::OP_SCAN_RESULT) m_pend = 1'b0;
		save = k == flags_pkg::OP_ENTER || k == flags_pkg::OP_BR_COMM || intr;
		stk = k == flags_pkg::OP_ENTER && !intr;
		chr = {m_code, m_ovf, m_cmp};
		if (save) m_ovf = 1'b0;
		if (k == flags_pkg::OP_BR_COMM || intr) {m_ctl, m_code, m_cmp} = 4'h8;
		if (save) {sv_stk, sv_chr} = {stk, chr};
		if (save && stk) stk_chr = chr;
		if (save && !stk) res_chr = chr;
		er = '0;
		er.valid = 1'b1;
		er.inhibit = ovn;
		er.priv_reject = k == flags_pkg::OP_PRIV && !bz;
		er.code_apply = k inside {flags_pkg::OP_ARITH, flags_pkg::OP_FLOAT, flags_pkg::OP_EDIT,
			flags_pkg::OP_MULT, flags_pkg::OP_MOVE_NUM, flags_pkg::OP_MOVE_ALPHA,
			flags_pkg::OP_MOVE_REPEAT, flags_pkg::OP_TRANSLATE, flags_pkg::OP_SCAN_DELIM};
		er.code_ascii = cb;
		er.save = save;
		er.save_stack = stk;
		er.save_char = save ? chr : 4'h0;
		er.take_intr = intr;
		m_base = bz;
		seq_inst.issue(k, b, bz, gap);
		#1;
		gr = o_resp;
		if (!gr.save) gr.save_char = 4'h0;
		check(32'(gr), 32'(er));
		check(32'(gr.save_char), 32'(er.save_char));
		gs = {o_intr_pending, o_control_state, o_overflow, o_cmp, o_code_ascii, o_mode, o_priv_ok};
		es = {m_pend, m_ctl, m_ovf, m_cmp, m_code, !m_ctl, !bz, bz};
		check(32'(gs), 32'(es));
		check(32'(gs[7:3]), 32'(es[7:3]));
	endtask : step

	initial begin
		repeat (20000) @(posedge i_clk_sys);
		fail_count++;
		print_verdict();
	end

	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		@(posedge i_clk_sys);
		#1;
		check(32'({o_control_state, o_overflow, o_cmp, o_code_ascii}), 32'h10);
		bus_write(flags_pkg::ADDR_CTRL, 32'h1, flags_pkg::RESP_OKAY);
		m_pend = 1'b1;
		bus_read(flags_pkg::ADDR_STATUS, status_word(), flags_pkg::RESP_OKAY);
		step(flags_pkg::OP_ARITH, 5'h13, 1'b1, 1);
		step(flags_pkg::OP_BR_REINST, 5'h00, 1'b1, 1);
		step(flags_pkg::OP_COMPARE, 5'h02, 1'b0, 2);
		bus_read(flags_pkg::ADDR_SAVED, {27'h0, sv_stk, sv_chr}, flags_pkg::RESP_OKAY);
		bus_write(flags_pkg::ADDR_CTRL, 32'h2, flags_pkg::RESP_OKAY);
		m_pend = 1'b0;
		@(posedge i_clk_sys);
		i_io_complete <= 1'b1;
		@(posedge i_clk_sys);
		i_io_complete <= 1'b0;
		m_pend = 1'b1;
		bus_read(flags_pkg::ADDR_STATUS, status_word(), flags_pkg::RESP_OKAY);
		bus_write(flags_pkg::ADDR_CTRL, 32'h2, flags_pkg::RESP_OKAY);
		m_pend = 1'b0;
		// unmapped place: refused, nothing changes
		bus_write(8'h0c, 32'h1, flags_pkg::RESP_SLVERR);
		bus_read(8'h0c, 32'h0, flags_pkg::RESP_SLVERR);
		bus_read(flags_pkg::ADDR_STATUS, status_word(), flags_pkg::RESP_OKAY);
		for (int i = 0; i < 600; i++) begin
			rng = xorshift(rng);
			step(flags_pkg::op_e'(5'(rng % 24)), rng[12:8], rng[16], 1 + int'(rng[21:20]));
		end
		step(flags_pkg::OP_SET_MODE, 5'h01, 1'b1, 1);
		step(flags_pkg::OP_ARITH, 5'h16, 1'b1, 1);
		@(posedge i_clk_sys);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		@(posedge i_clk_sys);
		#1;
		check(32'({o_control_state, o_overflow, o_cmp, o_code_ascii}), 32'h10);
		print_verdict();
	end
endmodule : test_processor_status_flags

/* File: verilog/flags_pkg.sv */
// constants, enumerations and carriers for the processor status flag block
package flags_pkg;

	// status character layout (code mode, overflow, comparison pair)
	localparam int CHR_W = 4;
	localparam int CHR_CODE_POS = 3;
	localparam int CHR_OVF_POS = 2;
	localparam int CHR_CMP_LSB = 0;
	localparam logic [3:0] CHR_RST = 4'h0;

	// comparison codes
	localparam logic [1:0] CMP_NONE = 2'h0;
	localparam logic [1:0] CMP_GREATER = 2'h1;
	localparam logic [1:0] CMP_LESS = 2'h2;
	localparam logic [1:0] CMP_EQUAL = 2'h3;

	// code mode flag values
	localparam logic CODE_EBCDIC = 1'b0;
	localparam logic CODE_USASCII = 1'b1;

	// state after reset: the operating system starts in control state
	localparam logic RST_CONTROL = 1'b1;

	// register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SAVED = 8'h08;

	// control register: write-one pulses
	localparam int CTRL_POST_POS = 0;
	localparam int CTRL_CLEAR_POS = 1;

	// status register fields
	localparam int STAT_CHR_LSB = 0;
	localparam int STAT_CTL_POS = 4;
	localparam int STAT_BASE0_POS = 5;
	localparam int STAT_INTR_POS = 6;
	localparam int STAT_MODE_LSB = 8;

	// saved register fields
	localparam int SAVED_CHR_LSB = 0;
	localparam int SAVED_STACK_POS = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_CTL_ZERO,
		MODE_CTL_NONZERO,
		MODE_NRM_ZERO,
		MODE_NRM_NONZERO
	} mode_e;

	typedef enum logic [4:0] {
		OP_OTHER, OP_ARITH, OP_MULT, OP_FLOAT, OP_COMPARE, OP_MOVE_NUM,
		OP_MOVE_ALPHA, OP_MOVE_REPEAT, OP_TRANSLATE, OP_BIT_TEST, OP_LOGICAL,
		OP_SCAN, OP_SCAN_DELIM, OP_EDIT, OP_SCAN_RESULT, OP_SEARCH,
		OP_BRANCH_COND, OP_BRANCH_OVF, OP_SET_MODE, OP_BR_COMM, OP_BR_REINST,
		OP_ENTER, OP_EXIT, OP_PRIV
	} op_e;

	// one completed instruction from the sequencer
	typedef struct packed {
		logic valid;
		op_e kind;
		logic ovf;
		logic exp_ovf;
		logic [1:0] cmp;
		logic mode_val;
		logic [3:0] char_in;
	} op_s;

	// answer to the sequencer, one cycle after the instruction
	typedef struct packed {
		logic valid;
		logic inhibit;
		logic priv_reject;
		logic code_apply;
		logic code_ascii;
		logic save;
		logic save_stack;
		logic [3:0] save_char;
		logic take_intr;
	} resp_s;

endpackage : flags_pkg

/* File: verilog/processor_status_flags.sv */
// processor state, condition flags and status character save and restore
//
// Behaviour
// RULE_01: one of four state and base modes
// RULE_02: control state holds off interrupt branch
// RULE_03: normal state lets interrupt branch happen
// RULE_04: privileged instructions rejected unless base zero
// RULE_05: overflow completes, inhibits data, sets flag
// RULE_06: overflow sticky across operations
// RULE_07: only listed movers and arithmetic set overflow
// RULE_08: floating exponent out of range sets overflow
// RULE_09: branch on overflow resets the flag
// RULE_10: comparison codes none, greater, less, equal
// RULE_11: only listed instructions write comparison, shown on console
// RULE_12: conditional branches keep comparison bits
// RULE_13: code flag clear EBCDIC, set USASCII
// RULE_14: set mode instruction writes code flag
// RULE_15: listed instructions follow the code flag
// RULE_16: character packs code, overflow, comparison pair
// RULE_17: communicate or interrupt branch saves, clears, enters control
// RULE_18: reinstate restores flags from reserved character
// RULE_19: enter saves flags to stack, clears overflow; no stack save when the enter is followed by an interrupt branch
// RULE_20: exit restores flags from stack character
// RULE_21: pending interrupt at normal completion branches
// RULE_22: state flag changes only by those branches
// RULE_23: reset clears all three flags
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps

module processor_status_flags (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// sequencer side
	input wire flags_pkg::op_s i_op,
	input wire logic i_base_zero,
	input wire logic i_io_complete,
	output flags_pkg::resp_s o_resp,
	output flags_pkg::mode_e o_mode,
	output logic o_control_state,
	output logic o_priv_ok,
	output logic o_intr_pending,
	output logic o_overflow,
	output logic [1:0] o_cmp,
	output logic o_code_ascii,
	// axi4-lite slave
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [flags_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [flags_pkg::ADDR_W-1:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp
);

	typedef struct packed {
		logic control_st;
		logic overflow;
		logic [1:0] cmp;
		logic code;
		logic intr;
		flags_pkg::mode_e mode;
		logic priv_ok;
		flags_pkg::resp_s resp;
		logic [3:0] saved_char;
		logic saved_stack;
		logic awready;
		logic wready;
		logic aw_got;
		logic [flags_pkg::ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_s;

	state_s st_ff;
	state_s nxt_st;

	function automatic logic can_overflow(input flags_pkg::op_e k);
		can_overflow = (k == flags_pkg::OP_ARITH) || (k == flags_pkg::OP_FLOAT) ||
			(k == flags_pkg::OP_MOVE_NUM) || (k == flags_pkg::OP_MOVE_ALPHA);
	endfunction : can_overflow

	function automatic logic writes_cmp(input flags_pkg::op_e k);
		case (k)
			flags_pkg::OP_ARITH, flags_pkg::OP_MULT, flags_pkg::OP_FLOAT,
			flags_pkg::OP_COMPARE, flags_pkg::OP_MOVE_NUM, flags_pkg::OP_MOVE_ALPHA,
			flags_pkg::OP_BIT_TEST, flags_pkg::OP_LOGICAL, flags_pkg::OP_SCAN,
			flags_pkg::OP_SCAN_DELIM, flags_pkg::OP_EDIT, flags_pkg::OP_SCAN_RESULT,
			flags_pkg::OP_SEARCH: writes_cmp = 1'b1;
			default: writes_cmp = 1'b0; // [RULE_12]
		endcase
	endfunction : writes_cmp

	function automatic logic code_sensitive(input flags_pkg::op_e k);
		case (k)
			flags_pkg::OP_ARITH, flags_pkg::OP_MULT, flags_pkg::OP_FLOAT,
			flags_pkg::OP_MOVE_NUM, flags_pkg::OP_MOVE_ALPHA, flags_pkg::OP_MOVE_REPEAT,
			flags_pkg::OP_TRANSLATE, flags_pkg::OP_SCAN_DELIM,
			flags_pkg::OP_EDIT: code_sensitive = 1'b1;
			default: code_sensitive = 1'b0;
		endcase
	endfunction : code_sensitive

	function automatic flags_pkg::mode_e mode_of(input logic ctl, input logic base0);
		if (ctl) begin
			mode_of = base0 ? flags_pkg::MODE_CTL_ZERO : flags_pkg::MODE_CTL_NONZERO;
		end else begin
			mode_of = base0 ? flags_pkg::MODE_NRM_ZERO : flags_pkg::MODE_NRM_NONZERO;
		end
	endfunction : mode_of

	function automatic logic [3:0] pack_char(input logic cd, input logic ov,
		input logic [1:0] cm);
		pack_char = '0;
		pack_char[flags_pkg::CHR_CODE_POS] = cd;
		pack_char[flags_pkg::CHR_OVF_POS] = ov;
		pack_char[flags_pkg::CHR_CMP_LSB +: 2] = cm;
	endfunction : pack_char

	function automatic logic known_addr(input logic [flags_pkg::ADDR_W-1:0] a);
		known_addr = (a == flags_pkg::ADDR_CTRL) || (a == flags_pkg::ADDR_STATUS) ||
			(a == flags_pkg::ADDR_SAVED);
	endfunction : known_addr

	always_comb begin
		logic sw_post;
		logic sw_clear;
		logic intr_clr;
		logic ov;
		logic cd;
		logic ctl;
		logic [1:0] cm;
		logic [31:0] rd;
		sw_post = 1'b0;
		sw_clear = 1'b0;
		intr_clr = 1'b0;
		rd = '0;
		nxt_st = st_ff;
		nxt_st.resp = '0;
		ov = st_ff.overflow;
		cd = st_ff.code;
		ctl = st_ff.control_st;
		cm = st_ff.cmp;

		// write channel: address and data taken in either order
		if (st_ff.bvalid && i_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (i_awvalid && st_ff.awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.aw_addr = i_awaddr;
		end
		if (i_wvalid && st_ff.wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.w_data = i_wdata;
			nxt_st.w_strb = i_wstrb;
		end
		if (nxt_st.aw_got && nxt_st.w_got && !nxt_st.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = known_addr(nxt_st.aw_addr) ? flags_pkg::RESP_OKAY :
				flags_pkg::RESP_SLVERR;
			if (nxt_st.aw_addr == flags_pkg::ADDR_CTRL && nxt_st.w_strb[0]) begin
				sw_post = nxt_st.w_data[flags_pkg::CTRL_POST_POS];
				sw_clear = nxt_st.w_data[flags_pkg::CTRL_CLEAR_POS];
			end
		end
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

		// read channel: one read at a time, answered the cycle after acceptance
		if (st_ff.rvalid && i_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (i_arvalid && st_ff.arready) begin
			case (i_araddr)
				flags_pkg::ADDR_STATUS: begin
					rd[flags_pkg::STAT_CHR_LSB +: 4] = pack_char(st_ff.code, st_ff.overflow,
						st_ff.cmp);
					rd[flags_pkg::STAT_CTL_POS] = st_ff.control_st;
					rd[flags_pkg::STAT_BASE0_POS] = i_base_zero;
					rd[flags_pkg::STAT_INTR_POS] = st_ff.intr;
					rd[flags_pkg::STAT_MODE_LSB +: 2] = st_ff.mode;
				end
				flags_pkg::ADDR_SAVED: begin
					rd[flags_pkg::SAVED_CHR_LSB +: 4] = st_ff.saved_char;
					rd[flags_pkg::SAVED_STACK_POS] = st_ff.saved_stack;
				end
				default: rd = '0;
			endcase
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd;
			nxt_st.rresp = known_addr(i_araddr) ? flags_pkg::RESP_OKAY :
				flags_pkg::RESP_SLVERR;
		end
		nxt_st.arready = !nxt_st.rvalid;

		// instruction completion
		if (i_op.valid) begin
			nxt_st.resp.valid = 1'b1;
			// the instruction uses the coding in force when it started
			nxt_st.resp.code_apply = code_sensitive(i_op.kind); // [RULE_15]
			nxt_st.resp.code_ascii = st_ff.code; // [RULE_13]
			if (can_overflow(i_op.kind) && (i_op.ovf ||
				(i_op.kind == flags_pkg::OP_FLOAT && i_op.exp_ovf))) begin // [RULE_07] [RULE_08]
				// never cleared here: prior overflow survives the new operation
				ov = 1'b1; // [RULE_05] [RULE_06]
				nxt_st.resp.inhibit = 1'b1; // [RULE_05]
			end
			if (writes_cmp(i_op.kind)) begin
				cm = i_op.cmp; // [RULE_10] [RULE_11]
			end
			case (i_op.kind)
				flags_pkg::OP_PRIV: begin
					nxt_st.resp.priv_reject = !i_base_zero; // [RULE_04]
				end
				flags_pkg::OP_BRANCH_OVF: begin
					ov = 1'b0; // [RULE_09]
				end
				flags_pkg::OP_SET_MODE: begin
					cd = i_op.mode_val; // [RULE_14]
				end
				flags_pkg::OP_BR_COMM: begin
					nxt_st.resp.save = 1'b1; // [RULE_17]
					nxt_st.resp.save_char = pack_char(cd, ov, cm); // [RULE_16]
					ov = 1'b0;
					cm = flags_pkg::CMP_NONE;
					cd = flags_pkg::CODE_EBCDIC;
					ctl = 1'b1; // [RULE_22]
				end
				flags_pkg::OP_BR_REINST: begin
					ov = i_op.char_in[flags_pkg::CHR_OVF_POS]; // [RULE_18]
					cm = i_op.char_in[flags_pkg::CHR_CMP_LSB +: 2];
					cd = i_op.char_in[flags_pkg::CHR_CODE_POS];
					ctl = 1'b0; // [RULE_22]
				end
				flags_pkg::OP_ENTER: begin
					nxt_st.resp.save = 1'b1; // [RULE_19]
					nxt_st.resp.save_stack = 1'b1;
					nxt_st.resp.save_char = pack_char(cd, ov, cm); // [RULE_16]
					ov = 1'b0;
				end
				flags_pkg::OP_EXIT: begin
					ov = i_op.char_in[flags_pkg::CHR_OVF_POS]; // [RULE_20]
					cm = i_op.char_in[flags_pkg::CHR_CMP_LSB +: 2];
					cd = i_op.char_in[flags_pkg::CHR_CODE_POS];
				end
				flags_pkg::OP_SCAN_RESULT: begin
					intr_clr = 1'b1;
				end
				default: begin
				end
			endcase
			// automatic branch only from normal state, after the instruction's own effects
			if (!st_ff.control_st && st_ff.intr &&
				i_op.kind != flags_pkg::OP_BR_COMM) begin // [RULE_02] [RULE_03] [RULE_21]
				nxt_st.resp.take_intr = 1'b1;
				nxt_st.resp.save = 1'b1; // [RULE_17]
				nxt_st.resp.save_stack = 1'b0;
				nxt_st.resp.save_char = pack_char(cd, ov, cm);
				ov = 1'b0;
				cm = flags_pkg::CMP_NONE;
				cd = flags_pkg::CODE_EBCDIC;
				ctl = 1'b1; // [RULE_22]
			end
		end

		// a new interrupt wins over a clear in the same cycle
		nxt_st.intr = (st_ff.intr && !(intr_clr || sw_clear)) || i_io_complete || sw_post;
		nxt_st.overflow = ov;
		nxt_st.cmp = cm;
		nxt_st.code = cd;
		nxt_st.control_st = ctl;
		nxt_st.mode = mode_of(ctl, i_base_zero); // [RULE_01]
		nxt_st.priv_ok = i_base_zero; // [RULE_04]
		if (nxt_st.resp.save) begin
			nxt_st.saved_char = nxt_st.resp.save_char;
			nxt_st.saved_stack = nxt_st.resp.save_stack;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			st_ff <= '0; // [RULE_23]
			st_ff.control_st <= flags_pkg::RST_CONTROL;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_resp = st_ff.resp;
	assign o_mode = st_ff.mode;
	assign o_control_state = st_ff.control_st;
	assign o_priv_ok = st_ff.priv_ok;
	assign o_intr_pending = st_ff.intr;
	assign o_overflow = st_ff.overflow;
	assign o_cmp = st_ff.cmp; // [RULE_11]
	assign o_code_ascii = st_ff.code;
	assign o_awready = st_ff.awready;
	assign o_wready = st_ff.wready;
	assign o_bvalid = st_ff.bvalid;
	assign o_bresp = st_ff.bresp;
	assign o_arready = st_ff.arready;
	assign o_rvalid = st_ff.rvalid;
	assign o_rdata = st_ff.rdata;
	assign o_rresp = st_ff.rresp;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	sequence ctl_done(flags_pkg::op_e k);
		i_op.valid && i_op.kind == k && st_ff.control_st;
	endsequence

	sequence normal_done;
		i_op.valid && !st_ff.control_st && st_ff.intr && i_op.kind != flags_pkg::OP_BR_COMM;
	endsequence

	sequence flags_cleared;
		st_ff.overflow == 1'b0 && st_ff.cmp == flags_pkg::CMP_NONE &&
			st_ff.code == flags_pkg::CODE_EBCDIC;
	endsequence

	ovf_sticky_a: assert property (st_ff.overflow && !i_op.valid |=> st_ff.overflow) // [RULE_06]
		else $error("overflow flag dropped without an instruction");

	ovf_set_a: assert property (ctl_done(flags_pkg::OP_ARITH) ##0 i_op.ovf // [RULE_05]
		|=> st_ff.resp.inhibit && st_ff.overflow)
		else $error("arithmetic overflow did not set flag and inhibit");

	mult_ovf_a: assert property (ctl_done(flags_pkg::OP_MULT) ##0 !st_ff.overflow // [RULE_07]
		|=> !st_ff.overflow && !st_ff.resp.inhibit)
		else $error("multiply set overflow");

	br_ovf_a: assert property (i_op.valid && i_op.kind == flags_pkg::OP_BRANCH_OVF // [RULE_09]
		|=> !st_ff.overflow)
		else $error("branch on overflow left flag set");

	cond_keep_a: assert property (ctl_done(flags_pkg::OP_BRANCH_COND) // [RULE_12]
		|=> st_ff.cmp == $past(st_ff.cmp))
		else $error("conditional branch changed comparison");

	priv_gate_a: assert property (i_op.valid && i_op.kind == flags_pkg::OP_PRIV // [RULE_04]
		|=> st_ff.resp.priv_reject == !$past(i_base_zero))
		else $error("privileged check wrong for base");

	intr_hold_a: assert property (i_op.valid && st_ff.control_st && st_ff.intr // [RULE_02]
		|=> !st_ff.resp.take_intr)
		else $error("interrupt branch taken in control state");

	auto_branch_a: assert property (normal_done // [RULE_21]
		|=> st_ff.resp.take_intr && st_ff.control_st ##0 flags_cleared)
		else $error("pending interrupt not branched at normal completion");

	comm_save_a: assert property (i_op.valid && i_op.kind == flags_pkg::OP_BR_COMM // [RULE_17]
		|=> st_ff.resp.save && st_ff.control_st && st_ff.resp.save_char ==
			{$past(st_ff.code), $past(st_ff.overflow), $past(st_ff.cmp)} ##0 flags_cleared)
		else $error("communicate branch did not save and clear");

	reinst_a: assert property (ctl_done(flags_pkg::OP_BR_REINST) // [RULE_18]
		|=> !st_ff.control_st && {st_ff.code, st_ff.overflow, st_ff.cmp} == $past(i_op.char_in))
		else $error("reinstate did not restore flags");

	enter_a: assert property (ctl_done(flags_pkg::OP_ENTER) // [RULE_19]
		|=> st_ff.resp.save_stack && !st_ff.overflow && st_ff.cmp == $past(st_ff.cmp))
		else $error("enter did not save and clear overflow");

	bresp_hold_a: assert property (st_ff.bvalid && !i_bready |=> st_ff.bvalid && $stable(st_ff.bresp))
		else $error("write response dropped before taken");

endmodule : processor_status_flags
